//--- pkg/dual_fifo_params.svh
`ifndef DUAL_FIFO_PARAMS_SVH
`define DUAL_FIFO_PARAMS_SVH

// Queue geometry
`define QUEUE_AW        11
`define QUEUE_DEPTH     12'h0800
`define DATA_W          36
`define OFFS_W          12
`define SYNC_STAGES     3

// Queue indices
`define FIRST_Q         0
`define SECOND_Q        1

// Port indices inside the clock pin vector
`define WIDE_P          0
`define READ_P          1
`define WRITE_P         2

// Register byte addresses
`define ADDR_CTRL       12'h000
`define ADDR_OFFS1      12'h004
`define ADDR_OFFS2      12'h008
`define ADDR_STATUS     12'h00C
`define ADDR_LEVELS     12'h010

// Control fields
`define CTRL_FIRST_WORD_FALL_THROUGH_MODE_BIT   0
`define CTRL_LOOP_BIT   1
`define CTRL_RESET      2'h0

// Offset register fields
`define OFFS_X_LSB      0
`define OFFS_Y_LSB      16
`define OFFS_X_RESET    12'h0008
`define OFFS_Y_RESET    12'h0008

// Level register fields
`define LVL_FIRST_LSB   0
`define LVL_SECOND_LSB  16

`endif

//--- pkg/dual_fifo_pkg.sv
`include "dual_fifo_params.svh"

package dual_fifo_pkg;

    typedef logic [`QUEUE_AW:0]   ptr_t;
    typedef logic [`DATA_W-1:0]   word_t;
    typedef logic [`OFFS_W-1:0]   offs_t;

    // Everything that arrives from the three port pins
    typedef struct packed {
        logic [2:0] clk;
        logic       wide_wr;
        logic       wide_rd;
        word_t      wide_data;
        logic       rd;
        logic       wr;
        word_t      wr_data;
    } pin_t;

endpackage

//--- src/dual_fifo_status_flag_sync.sv
`timescale 1ns/1ps
`include "dual_fifo_params.svh"

module dual_fifo_status_flag_sync
    import dual_fifo_pkg::*;
(
    // System
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Wide port
    input  wire logic        wide_port_clock,
    input  wire logic        wide_wr_en,
    input  wire logic        wide_rd_en,
    input  wire word_t       wide_wr_data,
    output word_t            wide_rd_data,
    output logic             wide_port_empty_outready_flag,
    output logic             wide_port_almost_empty_flag,
    output logic             wide_port_full_inready_flag,
    output logic             wide_port_almost_full_flag,
    // Read port
    input  wire logic        read_port_clock,
    input  wire logic        read_en,
    output word_t            read_data,
    output logic             read_port_empty_outready_flag,
    output logic             read_port_almost_empty_flag,
    // Write port
    input  wire logic        write_port_clock,
    input  wire logic        write_en,
    input  wire word_t       write_data,
    output logic             write_port_full_inready_flag,
    output logic             write_port_almost_full_flag
);
    // Words held in memory, output register excluded
    function automatic ptr_t fill(input ptr_t w, input ptr_t r);
        return w - r;
    endfunction
    // Pin sampling pipeline
    pin_t       pin_q [0:`SYNC_STAGES-1];
    pin_t       pin_d [0:`SYNC_STAGES-1];
    logic [2:0] lvl_q;
    logic [2:0] lvl_d;
    logic [2:0] edge_en;
    // Queue state, indexed by queue
    ptr_t   wp_q [0:1];
    ptr_t   wp_d [0:1];
    ptr_t   rp_q [0:1];
    ptr_t   rp_d [0:1];
    ptr_t   rps1_q [0:1];
    ptr_t   rps1_d [0:1];
    ptr_t   wps1_q [0:1];
    ptr_t   wps1_d [0:1];
    ptr_t   wps2_q [0:1];
    ptr_t   wps2_d [0:1];
    word_t  out_q [0:1];
    word_t  out_d [0:1];
    logic   [1:0] ef_q;
    logic   [1:0] ef_d;
    logic   [1:0] ae_q;
    logic   [1:0] ae_d;
    logic   [1:0] full_q;
    logic   [1:0] full_d;
    logic   [1:0] af_q;
    logic   [1:0] af_d;
    logic   [1:0] acc;
    logic   [1:0] load;
    word_t  mem [0:1][0:(1<<`QUEUE_AW)-1];
    // Per-queue steering
    logic   [1:0] wr_edge;
    logic   [1:0] rd_edge;
    logic   [1:0] wr_req;
    logic   [1:0] rd_req;
    word_t  wr_word [0:1];
    // Registers
    logic   [1:0] ctrl_q;
    logic   [1:0] ctrl_d;
    offs_t  offx_q [0:1];
    offs_t  offx_d [0:1];
    offs_t  offy_q [0:1];
    offs_t  offy_d [0:1];
    logic   first_word_fall_through_mode;
    logic   loop_sel;
    assign first_word_fall_through_mode     = ctrl_q[`CTRL_FIRST_WORD_FALL_THROUGH_MODE_BIT];
    assign loop_sel = ctrl_q[`CTRL_LOOP_BIT];
    // Three-stage pin pipeline; a clock level counts once stages agree
    always_comb begin
        pin_d[0] = '{clk: {write_port_clock, read_port_clock,
                           wide_port_clock},
                     wide_wr: wide_wr_en, wide_rd: wide_rd_en,
                     wide_data: wide_wr_data, rd: read_en,
                     wr: write_en, wr_data: write_data};
        for (int s = 1; s < `SYNC_STAGES; s++) begin
            pin_d[s] = pin_q[s-1];
        end
        for (int j = 0; j < 3; j++) begin
            lvl_d[j] = lvl_q[j];
            if (pin_q[1].clk[j] == pin_q[2].clk[j]) begin
                lvl_d[j] = pin_q[2].clk[j];
            end
            edge_en[j] = lvl_d[j] && !lvl_q[j];
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < `SYNC_STAGES; s++) begin
                pin_q[s] <= '0;
            end
            lvl_q <= '0;
        end else begin
            pin_q <= pin_d;
            lvl_q <= lvl_d;
        end
    end

    // Which port edge drives which side of each queue
    always_comb begin
        wr_edge[`FIRST_Q]  = edge_en[`WIDE_P];
        rd_edge[`FIRST_Q]  = edge_en[`READ_P];
        wr_edge[`SECOND_Q] = edge_en[`WRITE_P];
        rd_edge[`SECOND_Q] = edge_en[`WIDE_P];
        rd_req[`FIRST_Q]   = pin_q[2].rd;
        rd_req[`SECOND_Q]  = pin_q[2].wide_rd;
        wr_req[`SECOND_Q]  = pin_q[2].wr;
        wr_word[`SECOND_Q] = pin_q[2].wr_data;
        // Loopback feeds the wide side's output word, even a stale one
        if (loop_sel) begin
            wr_req[`FIRST_Q]  = pin_q[2].wide_wr || pin_q[2].wide_rd;
            wr_word[`FIRST_Q] = out_q[`SECOND_Q];
        end else begin
            wr_req[`FIRST_Q]  = pin_q[2].wide_wr;
            wr_word[`FIRST_Q] = pin_q[2].wide_data;
        end
    end

    // Pointer, flag and output register next state for both queues
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wp_d[i]   = wp_q[i];
            rps1_d[i] = rps1_q[i];
            full_d[i] = full_q[i];
            af_d[i]   = af_q[i];
            rp_d[i]   = rp_q[i];
            wps1_d[i] = wps1_q[i];
            wps2_d[i] = wps2_q[i];
            out_d[i]  = out_q[i];
            ef_d[i]   = ef_q[i];
            ae_d[i]   = ae_q[i];
            acc[i]    = 1'b0;
            load[i]   = 1'b0;
            // Write side: read pointer seen one write edge late, so a
            // read right before an edge waits one more edge
            if (wr_edge[i]) begin
                acc[i]    = wr_req[i] && full_q[i];
                wp_d[i]   = wp_q[i] + ptr_t'(acc[i]);
                rps1_d[i] = rp_q[i];
                full_d[i] = fill(wp_d[i], rps1_q[i])
                            != `QUEUE_DEPTH;
                af_d[i]   = fill(wp_d[i], rps1_q[i])
                            < (`QUEUE_DEPTH - offy_q[i]);
            end
            // Read side: two stages of write pointer view
            if (rd_edge[i]) begin
                wps1_d[i] = wp_q[i];
                wps2_d[i] = wps1_q[i];
                if (first_word_fall_through_mode) begin
                    if (!ef_q[i] || rd_req[i]) begin
                        load[i] = wps2_q[i] != rp_q[i];
                        ef_d[i] = load[i];
                    end
                end else begin
                    load[i] = rd_req[i] && ef_q[i];
                end
                rp_d[i] = rp_q[i] + ptr_t'(load[i]);
                if (load[i]) begin
                    out_d[i] = mem[i][rp_q[i][`QUEUE_AW-1:0]];
                end
                if (!first_word_fall_through_mode) begin
                    ef_d[i] = fill(wps1_q[i], rp_d[i]) != '0;
                end
                // Count after load, so the output word is excluded
                ae_d[i] = fill(wps1_q[i], rp_d[i]) > ptr_t'(offx_q[i]);
            end
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                wp_q[i]   <= '0;
                rp_q[i]   <= '0;
                rps1_q[i] <= '0;
                wps1_q[i] <= '0;
                wps2_q[i] <= '0;
                out_q[i]  <= '0;
            end
            ef_q   <= '0;
            ae_q   <= '0;
            full_q <= '1;
            af_q   <= '1;
        end else begin
            wp_q   <= wp_d;
            rp_q   <= rp_d;
            rps1_q <= rps1_d;
            wps1_q <= wps1_d;
            wps2_q <= wps2_d;
            out_q  <= out_d;
            ef_q   <= ef_d;
            ae_q   <= ae_d;
            full_q <= full_d;
            af_q   <= af_d;
        end
    end

    // Storage needs no reset; only written slots are ever read
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (acc[i]) begin
                mem[i][wp_q[i][`QUEUE_AW-1:0]] <= wr_word[i];
            end
        end
    end

    // Port outputs straight from output word and flag registers
    assign wide_rd_data                  = out_q[`SECOND_Q];
    assign read_data                     = out_q[`FIRST_Q];
    assign wide_port_empty_outready_flag = ef_q[`SECOND_Q];
    assign wide_port_almost_empty_flag   = ae_q[`SECOND_Q];
    assign wide_port_full_inready_flag   = full_q[`FIRST_Q];
    assign wide_port_almost_full_flag    = af_q[`FIRST_Q];
    assign read_port_empty_outready_flag = ef_q[`FIRST_Q];
    assign read_port_almost_empty_flag   = ae_q[`FIRST_Q];
    assign write_port_full_inready_flag  = full_q[`SECOND_Q];
    assign write_port_almost_full_flag   = af_q[`SECOND_Q];

    // APB register writes; zero wait states
    logic apb_wr;
    logic mapped;
    assign apb_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    always_comb begin
        ctrl_d = ctrl_q;
        offx_d = offx_q;
        offy_d = offy_q;
        if (apb_wr) begin
            unique case (paddr)
                `ADDR_CTRL:  ctrl_d = pwdata[1:0];
                `ADDR_OFFS1: begin
                    offx_d[`FIRST_Q] = pwdata[`OFFS_X_LSB +: `OFFS_W];
                    offy_d[`FIRST_Q] = pwdata[`OFFS_Y_LSB +: `OFFS_W];
                end
                `ADDR_OFFS2: begin
                    offx_d[`SECOND_Q] = pwdata[`OFFS_X_LSB +: `OFFS_W];
                    offy_d[`SECOND_Q] = pwdata[`OFFS_Y_LSB +: `OFFS_W];
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
            for (int i = 0; i < 2; i++) begin
                offx_q[i] <= `OFFS_X_RESET;
                offy_q[i] <= `OFFS_Y_RESET;
            end
        end else begin
            ctrl_q <= ctrl_d;
            offx_q <= offx_d;
            offy_q <= offy_d;
        end
    end

    // Read mux; unmapped addresses answer with an error and zero
    always_comb begin
        prdata = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            `ADDR_CTRL:   prdata[1:0] = ctrl_q;
            `ADDR_OFFS1: begin
                prdata[`OFFS_X_LSB +: `OFFS_W] = offx_q[`FIRST_Q];
                prdata[`OFFS_Y_LSB +: `OFFS_W] = offy_q[`FIRST_Q];
            end
            `ADDR_OFFS2: begin
                prdata[`OFFS_X_LSB +: `OFFS_W] = offx_q[`SECOND_Q];
                prdata[`OFFS_Y_LSB +: `OFFS_W] = offy_q[`SECOND_Q];
            end
            `ADDR_STATUS: prdata[7:0] = {af_q, full_q, ae_q, ef_q};
            `ADDR_LEVELS: begin
                prdata[`LVL_FIRST_LSB +: `QUEUE_AW+1] =
                    fill(wp_q[`FIRST_Q], rp_q[`FIRST_Q]);
                prdata[`LVL_SECOND_LSB +: `QUEUE_AW+1] =
                    fill(wp_q[`SECOND_Q], rp_q[`SECOND_Q]);
            end
            default: mapped = 1'b0;
        endcase
        pslverr = psel && penable && !mapped;
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_full_ignores;
        wr_edge[`SECOND_Q] && !full_q[`SECOND_Q]
            |=> wp_q[`SECOND_Q] == $past(wp_q[`SECOND_Q]);
    endproperty
    a_full_ignores: assert property (p_full_ignores)
        else $error("write taken while full");
    property p_full_at_depth;
        $fell(full_q[`SECOND_Q]) |-> ptr_t'(wp_q[`SECOND_Q]
            - $past(rps1_q[`SECOND_Q])) == `QUEUE_DEPTH;
    endproperty
    a_full_at_depth: assert property (p_full_at_depth)
        else $error("full flag fell below depth");
    // Loaded word must be the stored word at the old read pointer
    property p_rp_step;
        rp_q[`FIRST_Q] != $past(rp_q[`FIRST_Q]) |->
            rp_q[`FIRST_Q] == ptr_t'($past(rp_q[`FIRST_Q]) + 1'b1)
            && out_q[`FIRST_Q] ==
               mem[`FIRST_Q][$past(rp_q[`FIRST_Q][`QUEUE_AW-1:0])];
    endproperty
    a_rp_step: assert property (p_rp_step)
        else $error("read pointer jumped");
    property p_first_word_fall_through_mode_rise_loads;
        first_word_fall_through_mode && $rose(ef_q[`FIRST_Q]) |->
            rp_q[`FIRST_Q] == ptr_t'($past(rp_q[`FIRST_Q]) + 1'b1);
    endproperty
    a_first_word_fall_through_mode_rise_loads: assert property (p_first_word_fall_through_mode_rise_loads)
        else $error("output ready rose without a load");
    property p_std_read_ignored;
        !first_word_fall_through_mode && rd_edge[`FIRST_Q] && !ef_q[`FIRST_Q]
            |=> rp_q[`FIRST_Q] == $past(rp_q[`FIRST_Q]);
    endproperty
    a_std_read_ignored: assert property (p_std_read_ignored)
        else $error("read taken while empty");
    property p_wp_step;
        acc[`SECOND_Q] |=>
            wp_q[`SECOND_Q] == ptr_t'($past(wp_q[`SECOND_Q]) + 1'b1);
    endproperty
    a_wp_step: assert property (p_wp_step)
        else $error("write pointer did not advance");
    property p_ae_level;
        ae_q[`FIRST_Q] |->
            fill(wp_q[`FIRST_Q], rp_q[`FIRST_Q]) > ptr_t'(offx_q[`FIRST_Q]);
    endproperty
    a_ae_level: assert property (p_ae_level)
        else $error("almost-empty high at or below offset");
    property p_ef_level;
        !first_word_fall_through_mode && ef_q[`FIRST_Q] |-> wp_q[`FIRST_Q] != rp_q[`FIRST_Q];
    endproperty
    a_ef_level: assert property (p_ef_level)
        else $error("empty flag high with no stored word");
    property p_full_free;
        full_q[`FIRST_Q] |->
            fill(wp_q[`FIRST_Q], rp_q[`FIRST_Q]) < `QUEUE_DEPTH;
    endproperty
    a_full_free: assert property (p_full_free)
        else $error("full flag high with no free slot");
    // Looped word must land in the first queue's storage
    property p_loop_feed;
        loop_sel && acc[`FIRST_Q] |=> $past(out_q[`SECOND_Q]) ==
            mem[`FIRST_Q][$past(wp_q[`FIRST_Q][`QUEUE_AW-1:0])];
    endproperty
    a_loop_feed: assert property (p_loop_feed)
        else $error("loopback word not from second queue");
    c_first_full: cover property ($fell(full_q[`FIRST_Q]));
    c_first_word_fall_through_mode_ready: cover property (first_word_fall_through_mode && $rose(ef_q[`SECOND_Q]));
    c_loop_write: cover property (loop_sel && acc[`FIRST_Q]);
    c_almost_empty: cover property ($rose(ae_q[`SECOND_Q]));
endmodule // dual_fifo_status_flag_sync

//--- testbench/port_host.sv
`timescale 1ns/1ps

// Host logic on the far side of the three FIFO ports
module port_host
    import dual_fifo_pkg::*;
(
    // Reference timing
    input  wire logic ref_clk,
    // Wide port
    output logic      wide_port_clock,
    output logic      wide_wr_en,
    output logic      wide_rd_en,
    output word_t     wide_wr_data,
    // Read port
    output logic      read_port_clock,
    output logic      read_en,
    // Write port
    output logic      write_port_clock,
    output logic      write_en,
    output word_t     write_data
);
    logic [2:0] pclk;

    // Port clocks stand still between transfers
    assign wide_port_clock  = pclk[0];
    assign read_port_clock  = pclk[1];
    assign write_port_clock = pclk[2];

    // Idle pins at time zero
    initial begin
        pclk         = 3'b000;
        wide_wr_en   = 1'b0;
        wide_rd_en   = 1'b0;
        wide_wr_data = '0;
        read_en      = 1'b0;
        write_en     = 1'b0;
        write_data   = '0;
    end

    // One port clock pulse: p is 0 wide, 1 read, 2 write
    // Pins held well around the rise so the pin sampler sees them settled;
    // released data is inverted so a stale value never looks valid.
    task automatic cycle(input int p, input logic [1:0] en, input word_t d);
        @(posedge ref_clk);
        if (p == 0) begin
            wide_wr_en   <= en[0];
            wide_rd_en   <= en[1];
            wide_wr_data <= d;
        end else if (p == 1) begin
            read_en <= en[1];
        end else begin
            write_en   <= en[0];
            write_data <= d;
        end
        repeat (2) @(posedge ref_clk);
        pclk[p] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        pclk         <= 3'b000;
        wide_wr_en   <= 1'b0;
        wide_rd_en   <= 1'b0;
        read_en      <= 1'b0;
        write_en     <= 1'b0;
        wide_wr_data <= ~wide_wr_data;
        write_data   <= ~write_data;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule // port_host

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "dual_fifo_params.svh"

// Compare a seen value with its expectation, count both outcomes
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
        end \
    end

module tb;
    import dual_fifo_pkg::*;

    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        slverr;
    logic        wide_port_clock, wide_wr_en, wide_rd_en, read_port_clock;
    logic        read_en, write_port_clock, write_en;
    word_t       wide_wr_data, wide_rd_data, read_data, write_data;
    logic        wide_port_empty_outready_flag, wide_port_almost_empty_flag;
    logic        wide_port_full_inready_flag, wide_port_almost_full_flag;
    logic        read_port_empty_outready_flag, read_port_almost_empty_flag;
    logic        write_port_full_inready_flag, write_port_almost_full_flag;
    int          num_errors, tests_run;

    dual_fifo_status_flag_sync dut (
        .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wide_port_clock, .wide_wr_en, .wide_rd_en,
        .wide_wr_data, .wide_rd_data, .wide_port_empty_outready_flag,
        .wide_port_almost_empty_flag, .wide_port_full_inready_flag,
        .wide_port_almost_full_flag, .read_port_clock, .read_en, .read_data,
        .read_port_empty_outready_flag, .read_port_almost_empty_flag,
        .write_port_clock, .write_en, .write_data,
        .write_port_full_inready_flag, .write_port_almost_full_flag
    );

    port_host host (
        .ref_clk, .wide_port_clock, .wide_wr_en, .wide_rd_en, .wide_wr_data,
        .read_port_clock, .read_en, .write_port_clock, .write_en, .write_data
    );

    // 25 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Distinct word per index so misordering shows up
    function automatic word_t wv(input int i);
        return word_t'(i) ^ 36'h9_a5a5_0000;
    endfunction

    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 16) begin
            num_errors++;
            tally_and_finish();
        end
        rdata  = prdata;
        slverr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Three-cycle reset, which also restores default offsets
    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the full-queue fill
    initial begin
        repeat (80000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end

    // Test sequence
    initial begin
        num_errors = 0;
        tests_run  = 0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        do_reset();
        `CHK("wide_empty", 1'b0, wide_port_empty_outready_flag)
        `CHK("read_ae", 1'b0, read_port_almost_empty_flag)
        `CHK("write_full", 1'b1, write_port_full_inready_flag)
        `CHK("wide_af", 1'b1, wide_port_almost_full_flag)
        apb(1'b0, `ADDR_CTRL, 32'h0);
        `CHK("ctrl", 32'h0000_0000, rdata)
        apb(1'b0, `ADDR_OFFS2, 32'h0);
        `CHK("offs2", 32'h0008_0008, rdata)
        apb(1'b0, 12'h014, 32'h0);
        `CHK("unmapped_err", 1'b1, slverr)
        `CHK("unmapped_data", 32'h0000_0000, rdata)
        apb(1'b0, `ADDR_STATUS, 32'h0);
        `CHK("status", 32'h0000_00f0, rdata)
        $display("test reset_values done");

        // Standard mode: write port into second queue, wide port reads
        host.cycle(2, 2'b01, wv(1));
        host.cycle(0, 2'b00, '0);
        `CHK("wide_empty", 1'b0, wide_port_empty_outready_flag)
        host.cycle(0, 2'b00, '0);
        `CHK("wide_empty", 1'b1, wide_port_empty_outready_flag)
        host.cycle(0, 2'b10, '0);
        `CHK("wide_rd_data", wv(1), wide_rd_data)
        `CHK("wide_empty", 1'b0, wide_port_empty_outready_flag)
        $display("test standard_read done");

        // Almost-empty threshold with offset 2 on the second queue
        do_reset();
        apb(1'b1, `ADDR_OFFS2, 32'h0008_0002);
        for (int i = 0; i < 2; i++) host.cycle(2, 2'b01, wv(i));
        repeat (2) host.cycle(0, 2'b00, '0);
        `CHK("wide_ae", 1'b0, wide_port_almost_empty_flag)
        host.cycle(2, 2'b01, wv(2));
        host.cycle(0, 2'b00, '0);
        `CHK("wide_ae", 1'b0, wide_port_almost_empty_flag)
        host.cycle(0, 2'b00, '0);
        `CHK("wide_ae", 1'b1, wide_port_almost_empty_flag)
        $display("test almost_empty done");

        // Fill second queue to full with almost-full offset 4
        do_reset();
        apb(1'b1, `ADDR_OFFS2, 32'h0004_0008);
        for (int i = 0; i < 2048; i++) begin
            if (i == 2043) `CHK("af", 1'b1, write_port_almost_full_flag)
            if (i == 2044) `CHK("af", 1'b0, write_port_almost_full_flag)
            if (i == 2047) `CHK("full", 1'b1, write_port_full_inready_flag)
            host.cycle(2, 2'b01, wv(i));
        end
        `CHK("full", 1'b0, write_port_full_inready_flag)
        host.cycle(2, 2'b01, wv(4000));
        apb(1'b0, `ADDR_LEVELS, 32'h0);
        `CHK("second_fill", 12'h800, rdata[27:16])
        repeat (2) host.cycle(0, 2'b00, '0);
        host.cycle(0, 2'b10, '0);
        `CHK("wide_rd_data", wv(0), wide_rd_data)
        host.cycle(2, 2'b00, '0);
        `CHK("full", 1'b0, write_port_full_inready_flag)
        host.cycle(2, 2'b00, '0);
        `CHK("full", 1'b1, write_port_full_inready_flag)
        $display("test full_flags done");

        // Fall-through mode on first queue: wide port writes, read port
        do_reset();
        apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
        host.cycle(0, 2'b01, wv(11));
        host.cycle(0, 2'b01, wv(12));
        `CHK("inready", 1'b1, wide_port_full_inready_flag)
        repeat (2) host.cycle(1, 2'b00, '0);
        `CHK("outready", 1'b0, read_port_empty_outready_flag)
        host.cycle(1, 2'b00, '0);
        `CHK("outready", 1'b1, read_port_empty_outready_flag)
        `CHK("read_data", wv(11), read_data)
        apb(1'b0, `ADDR_LEVELS, 32'h0);
        `CHK("first_fill", 12'h001, rdata[11:0])
        host.cycle(1, 2'b10, '0);
        `CHK("read_data", wv(12), read_data)
        host.cycle(1, 2'b10, '0);
        `CHK("outready", 1'b0, read_port_empty_outready_flag)
        `CHK("read_data", wv(12), read_data)
        $display("test fall_through done");

        // Loopback runs past an empty second queue, repeating its last word
        do_reset();
        apb(1'b1, `ADDR_CTRL, 32'h0000_0002);
        apb(1'b1, `ADDR_OFFS1, 32'h0008_0001);
        host.cycle(2, 2'b01, wv(7));
        repeat (2) host.cycle(0, 2'b00, '0);
        repeat (2) host.cycle(0, 2'b10, '0);
        apb(1'b1, `ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, `ADDR_LEVELS, 32'h0);
        `CHK("first_fill", 12'h002, rdata[11:0])
        repeat (2) host.cycle(1, 2'b00, '0);
        `CHK("read_ae", 1'b1, read_port_almost_empty_flag)
        `CHK("read_empty", 1'b1, read_port_empty_outready_flag)
        repeat (2) host.cycle(1, 2'b10, '0);
        `CHK("read_data", wv(7), read_data)
        $display("test loopback done");
        tally_and_finish();
    end
endmodule // tb
